/* nsc_loader.sv */
// Start-up configuration loader with password-guarded reprogramming
`timescale 1ns/100ps
module nsc_loader #(
  parameter int LOAD_LIMIT = nsc_pkg::T_LOAD_CYC, // Loading watchdog
  parameter logic [7:0] PASSWORD = 8'h5C // Arbitrary unlock value
) (
  input wire logic clk_sys, // System clock, 250 MHz
  input wire logic rst_n, // Power-on reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic reset_pin_n, // External reset pin, asynchronous
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic fault_in, // Hardware fault level, routed to the pin in fault mode
  input wire logic debug_in, // Debug accessory attached
  input wire logic sink_power_in, // Sink power path active
  output logic [3:0] overvoltage_margin_code, // Bus limit shift
  output logic [3:0] discharge_duration_coeff, // Discharge multiplier
  output logic discharge_off, // Bus discharge disabled
  output logic [1:0] pin_mode, // Pin function select
  output logic gp_pin, // General-purpose pin level
  output logic config_valid // Registers hold loaded values
);

  // Flow: power-on reset or a released reset pin starts a copy
  // Two stored words go into the working registers, one per cycle
  // Host access stays refused until the copy ends, so no half-loaded
  // word is ever read back or overwritten
  // The watchdog only guards against a stuck sequencer
  // Storage rewrites need the password and show after a reload

  // Non-volatile words; only power-on reset restores factory values
  // Limitation: flops keep nothing across power-on reset, so that
  // reset stands for a fresh part with factory contents
  logic [7:0] nvm_ff [nsc_pkg::NVM_WORDS];
  logic [7:0] cfg0_ff; // Working copy, margin and coefficient
  logic [7:0] cfg1_ff; // Working copy, discharge and pin mode
  nsc_pkg::nsc_state_type state_ff; // Loader state
  nsc_pkg::nsc_state_type nxt_state;
  logic copy_idx_ff; // Word being copied
  logic [31:0] load_cnt_ff; // Cycles spent loading
  logic unlock_ff; // Password accepted
  logic reject_ff; // Refused reprogram seen
  logic [2:0] pin_sync_ff; // Reset pin synchroniser
  logic pin_lvl_ff; // Filtered reset pin level
  logic pin_lvl_d_ff; // Level one cycle earlier
  logic [7:0] reg_rdata_ff; // Read data register
  logic pin_release; // Reset pin just released
  logic acc_ok; // Host access allowed
  logic prog_req; // Reprogram command written
  logic load_done; // Loading complete

  // Address match, used by several processes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // Reset pin crosses in through three flops
  // Reset to the pin's idle high level: a zero here would look like
  // a pin pulse and restart the load just after power-on reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_ff <= 3'h7;
    end else if (ce) begin
      pin_sync_ff <= {pin_sync_ff[1:0], reset_pin_n};
    end
  end

  // Level accepted once the last two stages agree
  // A glitch seen by one stage only is dropped
  // Costs one cycle of latency, well inside the loading budget
  // Reset value is high, matching the idle pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_lvl_ff <= 1'b1;
      pin_lvl_d_ff <= 1'b1;
    end else if (ce) begin
      if (pin_sync_ff[1] == pin_sync_ff[2]) begin
        pin_lvl_ff <= pin_sync_ff[2];
      end
      pin_lvl_d_ff <= pin_lvl_ff;
    end
  end

  // Rising edge of the filtered level rearms the copy
  assign pin_release = pin_lvl_ff & ~pin_lvl_d_ff;

  // Loading is finished after the last word or at the time limit
  // The limit is a backstop; the copy itself needs two cycles
  // Counter and limit are 32 bits so the full budget fits
  assign load_done = copy_idx_ff | (load_cnt_ff >= 32'(LOAD_LIMIT - 1));
  assign acc_ok = (state_ff == nsc_pkg::LD_RUN);
  assign prog_req = acc_ok & reg_wr & hit(reg_addr, nsc_pkg::ADDR_PROG)
    & (reg_wdata == nsc_pkg::PROG_GO);

  // Loader sequencing
  // A low pin level from any state parks the loader in hold
  // An illegal code also falls back to hold and reloads
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      // Held while the reset pin is low
      nsc_pkg::LD_HOLD: begin
        if (pin_lvl_ff) begin
          nxt_state = nsc_pkg::LD_COPY;
        end
      end
      // Copying stored words
      nsc_pkg::LD_COPY: begin
        if (!pin_lvl_ff) begin
          nxt_state = nsc_pkg::LD_HOLD;
        end else if (load_done) begin
          nxt_state = nsc_pkg::LD_RUN;
        end
      end
      // Normal operation
      nsc_pkg::LD_RUN: begin
        if (!pin_lvl_ff) begin
          nxt_state = nsc_pkg::LD_HOLD;
        end
      end
      default: begin
        nxt_state = nsc_pkg::LD_HOLD;
      end
    endcase
  end

  // Power-on reset release starts a load straight away
  // No hold state here: the pin filter already rests at idle
  // Copy begins on the first enabled edge after release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= nsc_pkg::LD_COPY;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // Word index and elapsed time while copying
  // Both clear whenever the loader leaves the copy state
  // so a cut load starts again from the first word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      copy_idx_ff <= 1'b0;
      load_cnt_ff <= 32'h0000_0000;
    end else if (ce) begin
      if (state_ff == nsc_pkg::LD_COPY && !load_done) begin
        copy_idx_ff <= 1'b1;
        load_cnt_ff <= load_cnt_ff + 32'h0000_0001;
      end else if (state_ff != nsc_pkg::LD_COPY || pin_release) begin
        // Rearm for the next load
        copy_idx_ff <= 1'b0;
        load_cnt_ff <= 32'h0000_0000;
      end
    end
  end

  // Working copies: filled from storage, then host writable
  // Loading has priority; host writes only land in normal operation
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg0_ff <= nsc_pkg::NVM0_RST;
      cfg1_ff <= nsc_pkg::NVM1_RST;
    end else if (ce) begin
      if (state_ff == nsc_pkg::LD_COPY) begin
        // One word per cycle
        if (!copy_idx_ff) begin
          cfg0_ff <= nvm_ff[0];
        end else begin
          cfg1_ff <= nvm_ff[1];
        end
      end else if (acc_ok && reg_wr) begin
        if (hit(reg_addr, nsc_pkg::ADDR_CFG0)) begin
          // Coefficient zero is out of range, keep the old one
          cfg0_ff[nsc_pkg::MARGIN_LSB +: 4] <=
            reg_wdata[nsc_pkg::MARGIN_LSB +: 4];
          if (reg_wdata[nsc_pkg::COEFF_LSB +: 4] != 4'h0) begin
            cfg0_ff[nsc_pkg::COEFF_LSB +: 4] <=
              reg_wdata[nsc_pkg::COEFF_LSB +: 4];
          end
        end else if (hit(reg_addr, nsc_pkg::ADDR_CFG1)) begin
          cfg1_ff <= {4'h0, reg_wdata[3:0]};
        end
      end
    end
  end

  // Storage is rewritten only with the password accepted
  // The software pin level is not kept; it always reloads as zero
  // A refused step is flagged in the status register instead
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nvm_ff[0] <= nsc_pkg::NVM0_RST;
      nvm_ff[1] <= nsc_pkg::NVM1_RST;
    end else if (ce) begin
      if (prog_req && unlock_ff) begin
        // Working copies become the new start-up defaults
        nvm_ff[0] <= cfg0_ff;
        nvm_ff[1] <= {5'h00, cfg1_ff[2:0]};
      end
    end
  end

  // Password latch; any wrong value or a program step relocks
  // Leaving normal operation relocks too, so a reset needs a new
  // password before the next program step
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      unlock_ff <= 1'b0;
    end else if (ce) begin
      if (state_ff != nsc_pkg::LD_RUN || prog_req) begin
        unlock_ff <= 1'b0;
      end else if (reg_wr && hit(reg_addr, nsc_pkg::ADDR_PASS)) begin
        unlock_ff <= (reg_wdata == PASSWORD);
      end
    end
  end

  // Sticky refusal flag; a new refusal wins over a clear
  // Storage stays as it was on a refused program step
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reject_ff <= 1'b0;
    end else if (ce) begin
      if (prog_req && !unlock_ff) begin
        reject_ff <= 1'b1;
      end else if (acc_ok && reg_wr && hit(reg_addr, nsc_pkg::ADDR_STAT)
                   && reg_wdata[nsc_pkg::STAT_REJECT]) begin
        reject_ff <= 1'b0;
      end
    end
  end

  // Read data stands one cycle; refused reads return zero
  // Zero outside the answer cycle keeps stale data off the port
  // Status busy bit always reads zero: reads are refused while busy
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (ce) begin
      reg_rdata_ff <= 8'h00;
      if (reg_rd && acc_ok) begin
        unique case (reg_addr)
          nsc_pkg::ADDR_CFG0: reg_rdata_ff <= cfg0_ff;
          nsc_pkg::ADDR_CFG1: reg_rdata_ff <= cfg1_ff;
          nsc_pkg::ADDR_STAT: begin
            reg_rdata_ff <= {5'h00, reject_ff, unlock_ff, 1'b0};
          end
          default: reg_rdata_ff <= 8'h00; // Unmapped and write-only
        endcase
      end
    end
  end

  // Pin function mux, registered so the pin never glitches
  // Costs one cycle of delay from the sources to the pin
  // Fault and debug sources are same-clock levels, not synchronised
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gp_pin <= 1'b0;
    end else if (ce) begin
      unique case (cfg1_ff[nsc_pkg::PINMODE_LSB +: 2])
        nsc_pkg::PIN_SW: gp_pin <= cfg1_ff[nsc_pkg::SWPIN_BIT];
        nsc_pkg::PIN_FAULT: gp_pin <= fault_in;
        nsc_pkg::PIN_DEBUG: gp_pin <= debug_in;
        nsc_pkg::PIN_SINK: gp_pin <= sink_power_in;
      endcase
    end
  end

  // Operating parameters come only from the working copies
  // Reprogrammed storage has no effect here until the next reload
  // The pin mode output mirrors the register for the pin logic
  assign overvoltage_margin_code = cfg0_ff[nsc_pkg::MARGIN_LSB +: 4];
  assign discharge_duration_coeff = cfg0_ff[nsc_pkg::COEFF_LSB +: 4];
  assign discharge_off = cfg1_ff[nsc_pkg::OFF_BIT];
  assign pin_mode = cfg1_ff[nsc_pkg::PINMODE_LSB +: 2];
  assign config_valid = acc_ok;
  assign reg_rdata = reg_rdata_ff;

endmodule

/* nsc_pkg.sv */
// Constants shared by the start-up configuration loader
package nsc_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_CFG0 = 8'h00; // Margin and discharge coeff
  localparam logic [7:0] ADDR_CFG1 = 8'h01; // Discharge off, pin mode
  localparam logic [7:0] ADDR_STAT = 8'h02; // Loader status
  localparam logic [7:0] ADDR_PASS = 8'h03; // Password entry
  localparam logic [7:0] ADDR_PROG = 8'h04; // Reprogram command
  // Field positions
  localparam int MARGIN_LSB = 0; // CFG0 [3:0]
  localparam int COEFF_LSB = 4; // CFG0 [7:4]
  localparam int OFF_BIT = 0; // CFG1 bit 0
  localparam int PINMODE_LSB = 1; // CFG1 [2:1]
  localparam int SWPIN_BIT = 3; // CFG1 bit 3
  localparam int STAT_BUSY = 0; // Loading in progress
  localparam int STAT_UNLOCK = 1; // Password accepted
  localparam int STAT_REJECT = 2; // Refused reprogram attempt
  localparam logic [7:0] PROG_GO = 8'h01; // Command value to program
  // Factory defaults of the non-volatile words
  localparam logic [3:0] MARGIN_RST = 4'hA; // 10 percent
  localparam logic [3:0] COEFF_RST = 4'h9; // 9 units of 84 ms
  localparam logic OFF_RST = 1'b0; // Discharge enabled
  localparam logic [1:0] PINMODE_RST = 2'h3; // Sink power indication
  localparam logic [7:0] NVM0_RST = {COEFF_RST, MARGIN_RST};
  localparam logic [7:0] NVM1_RST = {5'h00, PINMODE_RST, OFF_RST};
  // Pin function codes
  localparam logic [1:0] PIN_SW = 2'h0;
  localparam logic [1:0] PIN_FAULT = 2'h1;
  localparam logic [1:0] PIN_DEBUG = 2'h2;
  localparam logic [1:0] PIN_SINK = 2'h3;
  // Loading time limit
  localparam int CLK_MHZ = 250; // Clock rate
  localparam int T_LOAD_MS = 30; // Longest loading time
  localparam int T_LOAD_CYC = T_LOAD_MS * 1000 * CLK_MHZ; // Exact, 7500000 cycles
  localparam int NVM_WORDS = 2; // Stored parameter words
  // Loader states
  typedef enum logic [2:0] {
    LD_HOLD = 3'b001,
    LD_COPY = 3'b010,
    LD_RUN = 3'b100
  } nsc_state_type;
endpackage

/* nsc_host.sv */
// Host model that drives the plain register port
`timescale 1ns/100ps
module nsc_host (
  input logic clk_sys, // Clock
  input logic [7:0] reg_rdata, // Read data
  output logic [7:0] reg_addr, // Address
  output logic [7:0] reg_wdata, // Write data
  output logic reg_wr, // Write strobe
  output logic reg_rd // Read strobe
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  // One-cycle write; released data is inverted so stale values never help
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk_sys);
    {reg_wr, reg_wdata} <= {1'b0, ~d};
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule

/* nsc_loader_asserts.sv */
// Checker for the start-up configuration loader ports
`timescale 1ns/100ps
module nsc_loader_chk (
  input logic clk_sys, // Clock
  input logic rst_n, // Power reset
  input logic ce, // Clock enable
  input logic reset_pin_n, // Reset pin
  input logic [7:0] reg_addr, // Address
  input logic [7:0] reg_wdata, // Write data
  input logic reg_wr, // Write strobe
  input logic reg_rd, // Read strobe
  input logic [7:0] reg_rdata, // Read data
  input logic fault_in, // Fault level
  input logic [3:0] overvoltage_margin_code, // Margin
  input logic [3:0] discharge_duration_coeff, // Coefficient
  input logic discharge_off, // Discharge off
  input logic [1:0] pin_mode, // Pin mode
  input logic gp_pin, // Pin level
  input logic config_valid // Loaded
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic [7:0] wait_ff; // Cycles spent loading
  logic wr_ok; // Write the block takes
  assign wr_ok = ce && reg_wr && config_valid;
  // Saturates so a stuck loader keeps failing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) wait_ff <= 8'h00;
    else if (config_valid || !reset_pin_n) wait_ff <= 8'h00;
    else if (wait_ff != 8'hFF) wait_ff <= wait_ff + 8'h01;
  end
  cfg0_write_a: assert property (
    wr_ok && reg_addr == nsc_pkg::ADDR_CFG0 |=>
    overvoltage_margin_code == $past(reg_wdata[3:0]) &&
    discharge_duration_coeff == ($past(reg_wdata[7:4]) == 4'h0 ?
    $past(discharge_duration_coeff) : $past(reg_wdata[7:4])))
    else $error("cfg0 write not applied");
  cfg1_write_a: assert property (
    wr_ok && reg_addr == nsc_pkg::ADDR_CFG1 |=>
    {pin_mode, discharge_off} == $past(reg_wdata[2:0]))
    else $error("cfg1 write not applied");
  cfg0_read_a: assert property (ce && reg_rd && config_valid &&
    reg_addr == nsc_pkg::ADDR_CFG0 |=> reg_rdata ==
    $past({discharge_duration_coeff, overvoltage_margin_code}))
    else $error("cfg0 read differs from outputs");
  fault_pin_a: assert property (ce && config_valid &&
    pin_mode == nsc_pkg::PIN_FAULT ##1 config_valid |-> gp_pin == $past(fault_in))
    else $error("pin does not follow fault");
  load_time_a: assert property (wait_ff <= 8'h0A)
    else $error("loading took too long");
  hold_load_a: assert property (!reset_pin_n [*7] |-> !config_valid)
    else $error("valid while reset pin held");
  refuse_read_a: assert property (
    ce && reg_rd && !config_valid |=> reg_rdata == 8'h00)
    else $error("read answered while loading");
  rdata_idle_a: assert property ($past(ce) && !$past(reg_rd) |->
    reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  freeze_hold_a: assert property (!ce |=> $stable(reg_rdata) &&
    $stable(gp_pin) && $stable(overvoltage_margin_code))
    else $error("state moved with clock enable low");
  cover property (wr_ok && reg_addr == nsc_pkg::ADDR_PROG);
  cover property ($rose(config_valid));
  cover property (pin_mode == nsc_pkg::PIN_FAULT && gp_pin);
  cover property (!ce && reg_wr);
endmodule
bind nsc_loader nsc_loader_chk i_nsc_loader_chk (.clk_sys, .rst_n, .ce,
  .reset_pin_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .fault_in, .overvoltage_margin_code, .discharge_duration_coeff,
  .discharge_off, .pin_mode, .gp_pin, .config_valid);

/* nsc_loader_test.sv */
// Self-checking bench for the start-up configuration loader
`timescale 1ns/100ps
module nsc_loader_test;
  logic clk_sys = 1'b0, rst_n = 1'b0, reset_pin_n = 1'b1; // Clock, resets
  logic fault_in = 1'b0, debug_in = 1'b0, sink_power_in = 1'b1; // Sources
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v; // Register port
  logic reg_wr, reg_rd, gp_pin, discharge_off, config_valid; // Strobes, flags
  logic [3:0] margin, coeff; // Parameter outputs
  logic [1:0] pin_mode; // Pin function
  logic ce = 1'b1; // Clock enable
  int n_fail = 0, n_tests = 0; // Counters
  always #2 clk_sys = ~clk_sys;
  nsc_host i_nsc_host (.clk_sys, .reg_rdata, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd);
  nsc_loader #(.LOAD_LIMIT(4), .PASSWORD(8'hA7)) i_nsc_loader (.clk_sys,
    .rst_n, .ce, .reset_pin_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .fault_in, .debug_in, .sink_power_in,
    .overvoltage_margin_code(margin), .discharge_duration_coeff(coeff),
    .discharge_off, .pin_mode, .gp_pin, .config_valid);
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, exp);
    i_nsc_host.rd(a, v);
    chk(v, exp);
  endtask
  // Host holds off until loading ends; a hang counts as a mismatch
  task automatic wait_load;
    for (int i = 0; i < 40 && config_valid !== 1'b1; i++) @(negedge clk_sys);
    if (config_valid !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
  endtask
  // Outputs and register copies against the expected words
  task automatic cfg(input logic [7:0] w0, w1);
    chk({coeff, margin}, w0);
    chk({5'h00, pin_mode, discharge_off}, w1);
    rdc(nsc_pkg::ADDR_CFG0, w0);
    rdc(nsc_pkg::ADDR_CFG1, w1);
  endtask
  // Reset pin pulse with accesses poked in while it is held
  task automatic pin_reset;
    @(posedge clk_sys);
    reset_pin_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    i_nsc_host.wr(nsc_pkg::ADDR_CFG0, 8'h44);
    rdc(nsc_pkg::ADDR_CFG0, 8'h00);
    chk({7'h00, config_valid}, 8'h00);
    @(posedge clk_sys);
    reset_pin_n <= 1'b1;
    wait_load();
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_load();
    cfg(8'h9A, 8'h06);
    i_nsc_host.wr(nsc_pkg::ADDR_CFG0, 8'h05);
    rdc(nsc_pkg::ADDR_CFG0, 8'h95);
    i_nsc_host.wr(nsc_pkg::ADDR_CFG0, 8'hF0);
    chk({coeff, margin}, 8'hF0);
    // Clock enable low drops a write and freezes the copies
    @(posedge clk_sys);
    ce <= 1'b0;
    i_nsc_host.wr(nsc_pkg::ADDR_CFG0, 8'h22);
    chk({coeff, margin}, 8'hF0);
    @(posedge clk_sys);
    ce <= 1'b1;
    // Every pin function, inputs flipped between passes
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      {fault_in, debug_in, sink_power_in} <= {k[0], !k[0], k[0]};
      for (int m = 0; m < 4; m++) begin
        i_nsc_host.wr(nsc_pkg::ADDR_CFG1, {4'h0, !k[0], m[1:0], 1'b1});
        repeat (2) @(posedge clk_sys);
        #1 chk({4'h0, gp_pin, pin_mode, discharge_off},
          {4'h0, (m[0] ? k[0] : !k[0]), m[1:0], 1'b1});
      end
    end
    rdc(8'h20, 8'h00);
    rdc(nsc_pkg::ADDR_PASS, 8'h00);
    // Programming without the password is refused
    i_nsc_host.wr(nsc_pkg::ADDR_CFG0, 8'h37);
    i_nsc_host.wr(nsc_pkg::ADDR_CFG1, 8'h02);
    i_nsc_host.wr(nsc_pkg::ADDR_PROG, nsc_pkg::PROG_GO);
    rdc(nsc_pkg::ADDR_STAT, 8'h04);
    i_nsc_host.wr(nsc_pkg::ADDR_STAT, 8'h04);
    rdc(nsc_pkg::ADDR_STAT, 8'h00);
    pin_reset();
    cfg(8'h9A, 8'h06);
    i_nsc_host.wr(nsc_pkg::ADDR_CFG0, 8'h37);
    i_nsc_host.wr(nsc_pkg::ADDR_CFG1, 8'h02);
    i_nsc_host.wr(nsc_pkg::ADDR_PASS, 8'hA7);
    rdc(nsc_pkg::ADDR_STAT, 8'h02);
    i_nsc_host.wr(nsc_pkg::ADDR_PROG, nsc_pkg::PROG_GO);
    rdc(nsc_pkg::ADDR_STAT, 8'h00);
    i_nsc_host.wr(nsc_pkg::ADDR_CFG0, 8'h11);
    rdc(nsc_pkg::ADDR_CFG0, 8'h11);
    pin_reset();
    cfg(8'h37, 8'h02);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_load();
    cfg(8'h9A, 8'h06);
    wrap_up();
  end
endmodule
